// [src/ftb_pkg.sv]
// package for the fifo threshold and baud group select block
package ftb_pkg;
    // register byte addresses
    localparam logic [7:0] FTB_BAUD_FIFO_MODE_ADDR = 8'h20;
    localparam logic [7:0] FTB_CHAR_FMT_MODE_ADDR = 8'h21;
    localparam logic [7:0] FTB_WDOG_CHAR_X_EN_ADDR = 8'h2C;
    localparam logic [7:0] FTB_IRQ_STATUS_ADDR = 8'h30;
    localparam logic [7:0] FTB_IRQ_MASK_ADDR = 8'h31;
    localparam logic [7:0] FTB_GROUP_STATUS_ADDR = 8'h32;

    // reset values
    localparam logic [7:0] FTB_BAUD_FIFO_MODE_RST = 8'h00;
    localparam logic [7:0] FTB_CHAR_FMT_MODE_RST = 8'h00;
    localparam logic [7:0] FTB_WCX_LOW_RST = 8'h00;
    localparam logic [3:0] FTB_IRQ_MASK_RST = 4'h0;

    // field positions
    localparam int FTB_GROUP_LSB = 0;
    localparam int FTB_DEPTH_BIT = 3;
    localparam int FTB_THR_BIT = 6;
    localparam int FTB_DUP_LSB = 6;

    // baud group codes
    localparam logic [2:0] FTB_GROUP_NORMAL_CODE = 3'h0;
    localparam logic [2:0] FTB_GROUP_EXT1_CODE = 3'h1;
    localparam logic [2:0] FTB_GROUP_EXT2_CODE = 3'h4;

    // occupancy thresholds, small table then large table
    localparam logic [8:0] FTB_DEPTH_SMALL = 9'h008;
    localparam logic [8:0] FTB_DEPTH_LARGE = 9'h100;
    localparam logic [8:0] FTB_RX_S0 = 9'h001;
    localparam logic [8:0] FTB_RX_S1 = 9'h003;
    localparam logic [8:0] FTB_RX_S2 = 9'h006;
    localparam logic [8:0] FTB_RX_S3 = 9'h008;
    localparam logic [8:0] FTB_RX_L0 = 9'h001;
    localparam logic [8:0] FTB_RX_L1 = 9'h080;
    localparam logic [8:0] FTB_RX_L2 = 9'h0C0;
    localparam logic [8:0] FTB_RX_L3 = 9'h100;
    localparam logic [8:0] FTB_TX_S0 = 9'h008;
    localparam logic [8:0] FTB_TX_S1 = 9'h004;
    localparam logic [8:0] FTB_TX_S2 = 9'h006;
    localparam logic [8:0] FTB_TX_S3 = 9'h001;
    localparam logic [8:0] FTB_TX_L0 = 9'h100;
    localparam logic [8:0] FTB_TX_L1 = 9'h080;
    localparam logic [8:0] FTB_TX_L2 = 9'h0C0;
    localparam logic [8:0] FTB_TX_L3 = 9'h001;

    // decoded baud group
    typedef enum logic [1:0] {
        FTB_GRP_NORMAL = 2'b00,
        FTB_GRP_EXT1 = 2'b01,
        FTB_GRP_EXT2 = 2'b10,
        FTB_GRP_BAD = 2'b11
    } ftb_group_t;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ftb_bus_req_t;

    // fifo occupancy from the channel
    typedef struct packed {
        logic [8:0] rx_fill;
        logic [8:0] tx_fill;
    } ftb_fill_t;
endpackage

// [src/ftb_select.sv]
// baud group decode and fifo interrupt threshold selection
`timescale 1ns/1ps
module ftb_select
    import ftb_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // register port
    input wire ftb_bus_req_t bus_i,
    output logic [7:0] rdata_o,
    // fifo occupancy, same clock domain
    input wire ftb_fill_t fill_i,
    // decoded outputs
    output ftb_group_t baud_group_o,
    output logic group_bad_o,
    output logic large_depth_o,
    output logic rx_byte_available_o,
    output logic tx_space_available_o,
    output logic irq_o
);

    // mode registers
    logic [7:0] baud_and_fifo_mode_r;
    logic [7:0] char_format_mode_r;
    logic [5:0] wcx_low_r;
    logic [3:0] irq_status_r;
    logic [3:0] irq_status_nxt;
    logic [3:0] irq_mask_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rx_cond_d_r;
    logic tx_cond_d_r;

    // threshold lookup used for both directions
    function automatic logic [8:0] ftb_pick(input logic [1:0] code,
                                            input logic [8:0] t0, input logic [8:0] t1,
                                            input logic [8:0] t2, input logic [8:0] t3);
        logic [8:0] v;
        v = t0;
        unique case (code)
            2'b00: v = t0;
            2'b01: v = t1;
            2'b10: v = t2;
            2'b11: v = t3;
        endcase
        return v;
    endfunction

    // group decode, illegal codes flagged rather than guessed
    wire logic [2:0] group_code = baud_and_fifo_mode_r[FTB_GROUP_LSB +: 3];
    assign baud_group_o = (group_code == FTB_GROUP_NORMAL_CODE) ? FTB_GRP_NORMAL :
                          (group_code == FTB_GROUP_EXT1_CODE) ? FTB_GRP_EXT1 :
                          (group_code == FTB_GROUP_EXT2_CODE) ? FTB_GRP_EXT2 : FTB_GRP_BAD;
    assign group_bad_o = (baud_group_o == FTB_GRP_BAD); // host misuse is only reported

    // threshold code and depth select
    wire logic [1:0] thr_code = {baud_and_fifo_mode_r[FTB_THR_BIT], char_format_mode_r[FTB_THR_BIT]};
    assign large_depth_o = baud_and_fifo_mode_r[FTB_DEPTH_BIT];

    // empty positions from transmit fill; fill beyond depth saturates to zero
    wire logic [8:0] depth = large_depth_o ? FTB_DEPTH_LARGE : FTB_DEPTH_SMALL;
    wire logic [8:0] tx_empty = (fill_i.tx_fill >= depth) ? 9'h000 : 9'(depth - fill_i.tx_fill);

    // selected levels
    wire logic [8:0] rx_level = large_depth_o ?
        ftb_pick(thr_code, FTB_RX_L0, FTB_RX_L1, FTB_RX_L2, FTB_RX_L3) :
        ftb_pick(thr_code, FTB_RX_S0, FTB_RX_S1, FTB_RX_S2, FTB_RX_S3);
    wire logic [8:0] tx_level = large_depth_o ?
        ftb_pick(thr_code, FTB_TX_L0, FTB_TX_L1, FTB_TX_L2, FTB_TX_L3) :
        ftb_pick(thr_code, FTB_TX_S0, FTB_TX_S1, FTB_TX_S2, FTB_TX_S3);

    // pure combinational levels so they drop the same cycle the fill moves
    assign rx_byte_available_o = (fill_i.rx_fill >= rx_level);
    assign tx_space_available_o = (tx_empty >= tx_level);

    // status events: rx rise, tx rise, bad group written, unmapped access
    wire logic wr_mode = bus_i.wr && (bus_i.addr == FTB_BAUD_FIFO_MODE_ADDR);
    wire logic bad_wr = wr_mode && !(bus_i.wdata[2:0] == FTB_GROUP_NORMAL_CODE ||
                                     bus_i.wdata[2:0] == FTB_GROUP_EXT1_CODE ||
                                     bus_i.wdata[2:0] == FTB_GROUP_EXT2_CODE);
    wire logic mapped = (bus_i.addr == FTB_BAUD_FIFO_MODE_ADDR) || (bus_i.addr == FTB_CHAR_FMT_MODE_ADDR) ||
                        (bus_i.addr == FTB_WDOG_CHAR_X_EN_ADDR) || (bus_i.addr == FTB_IRQ_STATUS_ADDR) ||
                        (bus_i.addr == FTB_IRQ_MASK_ADDR) || (bus_i.addr == FTB_GROUP_STATUS_ADDR);
    wire logic [3:0] irq_event = {(bus_i.wr || bus_i.rd) && !mapped, bad_wr,
                                  tx_space_available_o && !tx_cond_d_r,
                                  rx_byte_available_o && !rx_cond_d_r};
    wire logic [3:0] irq_clear = (bus_i.wr && bus_i.addr == FTB_IRQ_STATUS_ADDR) ? bus_i.wdata[3:0] : 4'h0;
    // set beats clear so an event in the clearing cycle is kept
    assign irq_status_nxt = (irq_status_r & ~irq_clear) | irq_event;
    assign irq_o = |(irq_status_r & irq_mask_r);

    // read mux; enable register shows the shared mode bits on top
    always_comb begin
        rdata_nxt = 8'h00;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                FTB_BAUD_FIFO_MODE_ADDR: rdata_nxt = baud_and_fifo_mode_r;
                FTB_CHAR_FMT_MODE_ADDR: rdata_nxt = char_format_mode_r;
                FTB_WDOG_CHAR_X_EN_ADDR: rdata_nxt = {baud_and_fifo_mode_r[7:6], wcx_low_r};
                FTB_IRQ_STATUS_ADDR: rdata_nxt = {4'h0, irq_status_r};
                FTB_IRQ_MASK_ADDR: rdata_nxt = {4'h0, irq_mask_r};
                FTB_GROUP_STATUS_ADDR: rdata_nxt = {3'h0, group_bad_o, large_depth_o, thr_code, 1'b0} |
                                                   {6'h00, baud_group_o};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // register writes; both addresses reach the one copy of bits 7:6
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            baud_and_fifo_mode_r <= FTB_BAUD_FIFO_MODE_RST;
            char_format_mode_r <= FTB_CHAR_FMT_MODE_RST;
            wcx_low_r <= FTB_WCX_LOW_RST[5:0];
            irq_mask_r <= FTB_IRQ_MASK_RST;
        end else if (bus_i.wr) begin
            if (bus_i.addr == FTB_BAUD_FIFO_MODE_ADDR) begin
                baud_and_fifo_mode_r <= bus_i.wdata;
            end
            if (bus_i.addr == FTB_CHAR_FMT_MODE_ADDR) begin
                char_format_mode_r <= bus_i.wdata;
            end
            if (bus_i.addr == FTB_WDOG_CHAR_X_EN_ADDR) begin
                baud_and_fifo_mode_r[7:6] <= bus_i.wdata[7:6];
                wcx_low_r <= bus_i.wdata[5:0];
            end
            if (bus_i.addr == FTB_IRQ_MASK_ADDR) begin
                irq_mask_r <= bus_i.wdata[3:0];
            end
        end
    end

    // status, edge history and read data
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            irq_status_r <= 4'h0;
            // history starts at the idle levels (fill 0: rx low, tx high) so reset gives no false rise
            rx_cond_d_r <= 1'b0;
            tx_cond_d_r <= 1'b1;
            rdata_r <= 8'h00;
        end else begin
            irq_status_r <= irq_status_nxt;
            rx_cond_d_r <= rx_byte_available_o;
            tx_cond_d_r <= tx_space_available_o;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;

endmodule

// [test/ftb_select_assertions.sv]
// port checks for the select block
`timescale 1ns/1ps
module ftb_select_assertions
    import ftb_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // watched ports
    input wire ftb_bus_req_t bus_i,
    input wire logic [7:0] rdata_o,
    input wire ftb_fill_t fill_i,
    input wire ftb_group_t baud_group_o,
    input wire logic group_bad_o,
    input wire logic large_depth_o,
    input wire logic rx_byte_available_o,
    input wire logic tx_space_available_o,
    input wire logic irq_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // a write to the mode register
    sequence s_mode_wr;
        bus_i.wr && bus_i.addr == 8'h20;
    endsequence
    a_rx_empty_low: assert property (fill_i.rx_fill == 9'h000 |-> !rx_byte_available_o)
        else $error("rx condition with empty fifo");
    a_rx_full_high: assert property ((fill_i.rx_fill == 9'h100 || (!large_depth_o && fill_i.rx_fill == 9'h008))
        |-> rx_byte_available_o) else $error("rx condition missing when full");
    a_tx_empty_high: assert property (fill_i.tx_fill == 9'h000 |-> tx_space_available_o)
        else $error("tx condition missing when empty");
    a_tx_small_full: assert property (!large_depth_o && fill_i.tx_fill == 9'h008 |-> !tx_space_available_o)
        else $error("tx condition with no space");
    a_tx_large_full: assert property (large_depth_o && fill_i.tx_fill == 9'h100 |-> !tx_space_available_o)
        else $error("tx condition with no space");
    a_group_flag: assert property (group_bad_o == (baud_group_o == FTB_GRP_BAD))
        else $error("group flag disagrees with group");
    a_depth_write: assert property (s_mode_wr |=> large_depth_o == $past(bus_i.wdata[3]))
        else $error("depth select not taken from write");
    a_group_ext2: assert property (s_mode_wr ##0 bus_i.wdata[2:0] == 3'h4 |=> baud_group_o == FTB_GRP_EXT2)
        else $error("group code four not decoded");
endmodule

// [test/ftb_host_model.sv]
// host processor model on the register port
`timescale 1ns/1ps
module ftb_host_model
    import ftb_pkg::*;
(
    // clock
    input wire logic core_clk_i,
    // register port
    output ftb_bus_req_t bus_o,
    input wire logic [7:0] rdata_i
);
    initial bus_o = '0;
    // one strobe cycle; group codes outside the three listed come only from deliberate tests
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i) bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i) bus_o <= '0;
        @(negedge core_clk_i);
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i) bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i) bus_o <= '0;
        @(negedge core_clk_i) d = rdata_i;
    endtask
endmodule

// [test/tb_fifo_threshold_baud_group_select.sv]
// self-checking bench for the threshold and group select block
`timescale 1ns/1ps
module tb_fifo_threshold_baud_group_select;
    import ftb_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    ftb_bus_req_t bus_i;
    ftb_fill_t fill_i = '0;
    logic [7:0] rdata_o, rd_v;
    ftb_group_t baud_group_o;
    logic group_bad_o, large_depth_o, rx_byte_available_o, tx_space_available_o, irq_o;
    logic [8:0] d;
    logic [8:0] rx_t [8] = '{9'h001, 9'h003, 9'h006, 9'h008, 9'h001, 9'h080, 9'h0C0, 9'h100};
    logic [8:0] tx_t [8] = '{9'h008, 9'h004, 9'h006, 9'h001, 9'h100, 9'h080, 9'h0C0, 9'h001};
    logic [7:0] gc [4] = '{8'h00, 8'h01, 8'h04, 8'h02};
    int errors = 0;
    int tests_run = 0;
    always #4 core_clk_i = ~core_clk_i;
    ftb_host_model host(.core_clk_i, .bus_o(bus_i), .rdata_i(rdata_o));
    ftb_select dut(.core_clk_i, .rst_n_i, .bus_i, .rdata_o, .fill_i, .baud_group_o, .group_bad_o,
        .large_depth_o, .rx_byte_available_o, .tx_space_available_o, .irq_o);
    task automatic chk(string n, logic [8:0] e, logic [8:0] s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic fill(logic [8:0] r, logic [8:0] t);
        @(posedge core_clk_i) fill_i <= '{rx_fill: r, tx_fill: t};
        @(negedge core_clk_i);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog, far beyond the fewer than a hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge core_clk_i);
        errors++;
        $display("[FAIL] watchdog expected done seen hang");
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        // one step below and at each threshold, both depths, all codes
        for (int i = 0; i < 8; i++) begin
            host.wr(8'h20, {1'b0, i[1], 2'b00, i[2], 3'b000});
            host.wr(8'h21, {1'b0, i[0], 6'h00});
            d = i[2] ? 9'h100 : 9'h008;
            fill(rx_t[i] - 9'h001, d - tx_t[i] + 9'h001);
            chk("rx_below", 9'h000, rx_byte_available_o);
            chk("tx_below", 9'h000, tx_space_available_o);
            fill(rx_t[i], d - tx_t[i]);
            chk("rx_at", 9'h001, rx_byte_available_o);
            chk("tx_at", 9'h001, tx_space_available_o);
        end
        $display("thresholds done");
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h20, gc[i]);
            chk("group", 9'(i), baud_group_o);
            chk("group_bad", 9'(i == 3), group_bad_o);
        end
        host.wr(8'h20, 8'h00);
        host.wr(8'h2C, 8'hC0);
        host.rd(8'h20, rd_v);
        chk("mode_dup", 9'h0C0, rd_v);
        host.rd(8'h2C, rd_v);
        chk("wcx_dup", 9'h0C0, rd_v);
        host.rd(8'h32, rd_v);
        chk("group_status", 9'h006, rd_v);
        chk("depth_small", 9'h000, large_depth_o);
        fill(9'h000, 9'h1FF);
        chk("tx_overfill", 9'h000, tx_space_available_o);
        $display("group and duplicate done");
        // interrupt: raise, clear, mask, unmask
        host.wr(8'h20, 8'h00);
        host.wr(8'h21, 8'h00);
        fill(9'h000, 9'h000);
        host.wr(8'h30, 8'hFF);
        host.wr(8'h31, 8'h01);
        chk("irq_idle", 9'h000, irq_o);
        fill(9'h001, 9'h000);
        @(negedge core_clk_i);
        chk("irq_rx", 9'h001, irq_o);
        host.wr(8'h30, 8'h01);
        chk("irq_clear", 9'h000, irq_o);
        host.rd(8'h7F, rd_v);
        chk("unmapped", 9'h000, rd_v);
        chk("irq_masked", 9'h000, irq_o);
        host.wr(8'h31, 8'h09);
        chk("irq_unmask", 9'h001, irq_o);
        $display("interrupts done");
        print_verdict();
    end
endmodule
bind ftb_select ftb_select_assertions chk_i(.core_clk_i, .rst_n_i, .bus_i, .rdata_o, .fill_i, .baud_group_o,
    .group_bad_o, .large_depth_o, .rx_byte_available_o, .tx_space_available_o, .irq_o);
